/* File: src/usb_irq_pkg.sv */
package usb_irq_pkg;
   // register indices; byte address is four times the index
   localparam logic [12:0] IDX_STATUS    = 13'h1ff7;
   localparam logic [12:0] IDX_MASK      = 13'h1ff6;
   localparam logic [12:0] IDX_ACK       = 13'h1ff5;
   localparam logic [12:0] IDX_ENABLE    = 13'h1ff3;
   localparam logic [12:0] IDX_SUSP_STAT = 13'h1ffa;
   localparam logic [12:0] IDX_SUSP_EN   = 13'h1ff9;
   localparam logic [12:0] IDX_SUSP_MASK = 13'h1ff8;
   localparam logic [12:0] IDX_FRAME_LO  = 13'h1ff0;
   localparam logic [12:0] IDX_FRAME_HI  = 13'h1ff1;
   localparam logic [12:0] IDX_EP_DIR    = 13'h1ff2;
   localparam logic [1:0]  BYTE_LANE     = 2'h0;

   // event status bit positions
   localparam int BIT_SOF  = 7;
   localparam int BIT_EOF2 = 6;
   localparam int BIT_RSVD = 5;
   localparam int BIT_FE3  = 4;
   localparam int BIT_HUB0 = 3;
   localparam int BIT_FE2  = 2;
   localparam int BIT_FE1  = 1;
   localparam int BIT_FE0  = 0;

   // suspend/resume status bit positions
   localparam int SB_SUSP   = 0;
   localparam int SB_RESUME = 1;
   localparam int SB_WAKE   = 2;
   localparam int SB_BUSRST = 3;

   // endpoint slots: 0..3 function endpoints, 4 hub endpoint 0
   localparam int N_EP     = 5;
   localparam int EP_HUB0  = 4;

   // reset values
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [3:0]  RST_NIB   = 4'h0;
   localparam logic [15:0] RST_CNT   = 16'h0000;
   localparam logic [7:0]  RSVD_MASK = 8'hdf;

   // frame timing
   localparam int FRAME_PERIOD_NS  = 1000000;
   localparam int CLK_PERIOD_NS    = 25;
   localparam int FRAME_CYCLES     = FRAME_PERIOD_NS / CLK_PERIOD_NS;
   localparam int EOF2_LEAD_CYCLES = 10;

   // endpoint control/status register change strobes
   typedef struct packed {
      logic rx_out_set;
      logic txrdy_clr;
      logic tx_cmpl_set;
      logic rx_setup_set;
   } ep_csr_evt_type;

   // bus-level events from the serial engine
   typedef struct packed {
      logic sof_valid;
      logic remote_wakeup;
      logic global_suspend;
      logic resume;
      logic bus_reset;
   } bus_evt_type;

   typedef enum logic [0:0] {
      HUB_ACTIVE  = 1'b0,
      HUB_SUSPEND = 1'b1
   } hub_state_type;
endpackage

/* File: src/usb_irq_sources.sv */
// Behaviour
// - valid start-of-frame raises its event and stores the frame number in two registers
// - frame timer raises end-of-frame-point event ten cycles before next frame
// - endpoints configured IN raise event after IN token, transmit and acknowledge
// - remote wakeup request from the function raises its event
// - global suspend raises event and, unless resume comes in the same cycle, puts hub in suspend preparation
// - resume raises event and drives resume propagation
// - bus reset raises event only when separation from controller reset enabled
// - every source has its own enable, status and mask bit
// - suspend and resume events clear by writing zero to their bit
// - other events clear by writing one: status events via the acknowledge register, wakeup and bus reset via the suspend status register
// - endpoint triggers differ between control and non-control endpoints
// - received OUT packet sets status on control or OUT endpoints
// - ready cleared with transmit complete sets status on control or IN endpoints
// - received setup sets status on control endpoints only
// - transmit complete alone also sets the endpoint status bit
// - status register bit layout fixed, bit 5 reads zero
// - mask bit suppresses, enable bit allows; all reset to zero
//
// The APB slave port was chosen for this implementation.
module usb_irq_sources
   import usb_irq_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_CYCLES
) (
   // clock and reset
   input  wire logic           pclk,
   input  wire logic           presetn,
   // apb slave
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [15:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   // serial engine events
   input  wire bus_evt_type    bus_evt,
   input  wire logic [10:0]    sof_frame,
   input  wire ep_csr_evt_type ep_evt [N_EP],
   // hub control and interrupt
   output logic                hub_suspend_prep,
   output logic                resume_propagate,
   output logic                usb_irq
);

   localparam logic [15:0] EOF2_AT = 16'(FRAME_LEN - EOF2_LEAD_CYCLES);
   localparam logic [15:0] LAST_AT = 16'(FRAME_LEN - 1);

   logic [7:0]    status_r;
   logic [7:0]    status_nxt;
   logic [7:0]    mask_r;
   logic [7:0]    enable_r;
   logic [3:0]    susp_r;
   logic [3:0]    susp_nxt;
   logic [3:0]    susp_en_r;
   logic [3:0]    susp_mask_r;
   logic [3:0]    ep_dir_r;
   logic [7:0]    frame_lo_r;
   logic [2:0]    frame_hi_r;
   logic [15:0]   fcnt_r;
   logic          frun_r;
   logic          eof2_hit;
   logic [N_EP-1:0] ep_hit;
   logic [7:0]    set_vec;
   logic [3:0]    susp_set;
   logic          acc;
   logic          wr;
   logic          rd_setup;
   logic [12:0]   idx;
   logic          mapped;
   logic          err_r;
   logic          irq_r;
   logic          prop_r;
   hub_state_type hub_r;

   // register decode
   assign idx      = paddr[14:2];
   assign acc      = psel & penable;
   assign rd_setup = psel & ~penable;
   assign wr       = acc & pwrite & ~err_r;
   assign pready   = 1'b1;
   assign pslverr  = acc & err_r;

   always_comb begin
      mapped = (paddr[1:0] == BYTE_LANE) && (paddr[15] == 1'b0) &&
               (idx == IDX_STATUS || idx == IDX_MASK || idx == IDX_ACK ||
                idx == IDX_ENABLE || idx == IDX_SUSP_STAT ||
                idx == IDX_SUSP_EN || idx == IDX_SUSP_MASK ||
                idx == IDX_FRAME_LO || idx == IDX_FRAME_HI ||
                idx == IDX_EP_DIR);
   end

   // read data and error captured in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         err_r  <= 1'b0;
      end else if (rd_setup) begin
         err_r  <= ~mapped;
         prdata <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (idx)
               IDX_STATUS:    prdata[7:0] <= status_r;
               IDX_MASK:      prdata[7:0] <= mask_r;
               IDX_ENABLE:    prdata[7:0] <= enable_r;
               IDX_SUSP_STAT: prdata[3:0] <= susp_r;
               IDX_SUSP_EN:   prdata[3:0] <= susp_en_r;
               IDX_SUSP_MASK: prdata[3:0] <= susp_mask_r;
               IDX_FRAME_LO:  prdata[7:0] <= frame_lo_r;
               IDX_FRAME_HI:  prdata[2:0] <= frame_hi_r;
               IDX_EP_DIR:    prdata[3:0] <= ep_dir_r;
               default:       prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software-written configuration
   // per-source enable and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r      <= RST_BYTE;
         enable_r    <= RST_BYTE;
         susp_en_r   <= RST_NIB;
         susp_mask_r <= RST_NIB;
         ep_dir_r    <= RST_NIB;
      end else if (wr) begin
         if (idx == IDX_MASK)      mask_r      <= pwdata[7:0] & RSVD_MASK;
         if (idx == IDX_ENABLE)    enable_r    <= pwdata[7:0] & RSVD_MASK;
         if (idx == IDX_SUSP_EN)   susp_en_r   <= pwdata[3:0];
         if (idx == IDX_SUSP_MASK) susp_mask_r <= pwdata[3:0];
         if (idx == IDX_EP_DIR)    ep_dir_r    <= {pwdata[3:1], 1'b0};
      end
   end

   // frame number capture
   // store frame number
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_lo_r <= RST_BYTE;
         frame_hi_r <= 3'h0;
      end else if (bus_evt.sof_valid) begin
         frame_lo_r <= sof_frame[7:0];
         frame_hi_r <= sof_frame[10:8];
      end
   end

   // hub frame timer, restarted by each start of frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcnt_r <= RST_CNT;
         frun_r <= 1'b0;
      end else if (bus_evt.sof_valid) begin
         fcnt_r <= RST_CNT;
         frun_r <= 1'b1;
      end else if (frun_r) begin
         fcnt_r <= (fcnt_r == LAST_AT) ? RST_CNT : fcnt_r + 16'h0001;
      end
   end

   assign eof2_hit = frun_r && (fcnt_r == EOF2_AT) && !bus_evt.sof_valid;

   // per-endpoint trigger decode
   for (genvar i = 0; i < N_EP; i++) begin : g_ep
      localparam bit IS_CTRL = (i == 0) || (i == EP_HUB0);
      // status bit of this slot
      localparam int SBIT    = (i == 3) ? BIT_FE3 : ((i == EP_HUB0) ? BIT_HUB0 : i);
      logic is_in;
      logic is_out;
      // control slots have no direction bit; hub slot lies beyond the direction register
      if (IS_CTRL) begin : g_ctl
         assign is_in  = 1'b0;
         assign is_out = 1'b0;
      end else begin : g_fn
         assign is_in  = ep_dir_r[i];
         assign is_out = ~ep_dir_r[i];
      end
      assign ep_hit[i] = (ep_evt[i].rx_out_set & (IS_CTRL | is_out))
                       | (ep_evt[i].txrdy_clr & ep_evt[i].tx_cmpl_set & (IS_CTRL | is_in))
                       | (ep_evt[i].rx_setup_set & IS_CTRL)
                       | ep_evt[i].tx_cmpl_set;

      a_txcmpl_sets: assert property (
         @(posedge pclk) disable iff (!presetn) ep_evt[i].tx_cmpl_set |=> status_r[SBIT])
         else $error("transmit complete did not set status");
   end

   always_comb begin
      set_vec           = 8'h00;
      set_vec[BIT_SOF]  = bus_evt.sof_valid;
      set_vec[BIT_EOF2] = eof2_hit;
      set_vec[BIT_FE3]  = ep_hit[3];
      set_vec[BIT_HUB0] = ep_hit[EP_HUB0];
      set_vec[BIT_FE2]  = ep_hit[2];
      set_vec[BIT_FE1]  = ep_hit[1];
      set_vec[BIT_FE0]  = ep_hit[0];
   end

   always_comb begin
      status_nxt = status_r;
      if (wr && idx == IDX_ACK) begin
         status_nxt = status_r & ~pwdata[7:0];
      end
      status_nxt = (status_nxt | set_vec) & RSVD_MASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= RST_BYTE;
      end else begin
         status_r <= status_nxt;
      end
   end

   // suspend/resume event sources
   always_comb begin
      susp_set            = 4'h0;
      susp_set[SB_SUSP]   = bus_evt.global_suspend;
      susp_set[SB_RESUME] = bus_evt.resume;
      susp_set[SB_WAKE]   = bus_evt.remote_wakeup;
      susp_set[SB_BUSRST] = bus_evt.bus_reset & susp_en_r[SB_BUSRST];
   end

   // suspend/resume clear by zero; others by one
   always_comb begin
      susp_nxt = susp_r;
      if (wr && idx == IDX_SUSP_STAT) begin
         susp_nxt[SB_SUSP]   = susp_r[SB_SUSP] & pwdata[SB_SUSP];
         susp_nxt[SB_RESUME] = susp_r[SB_RESUME] & pwdata[SB_RESUME];
         susp_nxt[SB_WAKE]   = susp_r[SB_WAKE] & ~pwdata[SB_WAKE];
         susp_nxt[SB_BUSRST] = susp_r[SB_BUSRST] & ~pwdata[SB_BUSRST];
      end
      susp_nxt = susp_nxt | susp_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         susp_r <= RST_NIB;
      end else begin
         susp_r <= susp_nxt;
      end
   end

   // hub suspend state and resume propagation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hub_r  <= HUB_ACTIVE;
         prop_r <= 1'b0;
      end else begin
         prop_r <= bus_evt.resume;
         unique case (hub_r)
            HUB_ACTIVE:  if (bus_evt.global_suspend && !bus_evt.resume) hub_r <= HUB_SUSPEND;
            HUB_SUSPEND: if (bus_evt.resume) hub_r <= HUB_ACTIVE;
         endcase
      end
   end

   assign hub_suspend_prep = (hub_r == HUB_SUSPEND);
   assign resume_propagate = prop_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (|(status_r & enable_r & ~mask_r))
                | (|(susp_r & susp_en_r & ~susp_mask_r));
      end
   end

   assign usb_irq = irq_r;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sof_status: assert property (
      bus_evt.sof_valid |=> status_r[BIT_SOF] && frame_lo_r == $past(sof_frame[7:0]))
      else $error("sof did not set status or frame");

   a_eof2_point: assert property (
      bus_evt.sof_valid ##1 (!bus_evt.sof_valid)[*8] |-> !status_r[BIT_EOF2] || $past(status_r[BIT_EOF2], 9))
      else $error("eof2 set too early after sof");

   a_eof2_count: assert property (
      frun_r && !bus_evt.sof_valid && fcnt_r == EOF2_AT |=> status_r[BIT_EOF2])
      else $error("eof2 not raised at its point");

   a_out_ep: assert property (
      ep_evt[1].rx_out_set && !ep_dir_r[1] |=> status_r[BIT_FE1])
      else $error("out endpoint event missed");

   a_setup_ctrl: assert property (
      ep_evt[2].rx_setup_set && !ep_evt[2].rx_out_set && !ep_evt[2].tx_cmpl_set
      && !status_r[BIT_FE2] |=> !status_r[BIT_FE2])
      else $error("setup set a non-control endpoint");

   a_busrst_gate: assert property (
      !susp_r[SB_BUSRST] && !susp_en_r[SB_BUSRST] |=> !susp_r[SB_BUSRST])
      else $error("bus reset event without separation");

   a_susp_zero_clr: assert property (
      wr && idx == IDX_SUSP_STAT && !pwdata[SB_RESUME] && !bus_evt.resume |=> !susp_r[SB_RESUME])
      else $error("resume not cleared by zero write");

   a_ack_clear: assert property (
      wr && idx == IDX_ACK && pwdata[BIT_FE0] && !ep_hit[0] |=> !status_r[BIT_FE0])
      else $error("acknowledge did not clear");

   a_rsvd_zero: assert property (
      !status_r[BIT_RSVD] && !mask_r[BIT_RSVD])
      else $error("reserved bit not zero");

   a_irq_mask: assert property (
      ((status_r & enable_r & ~mask_r) != 8'h00) |=> usb_irq)
      else $error("unmasked event gave no interrupt");

   // suspend/resume sources, endpoint typing and request gating
   a_wake_set: assert property (
      bus_evt.remote_wakeup |=> susp_r[SB_WAKE])
      else $error("remote wakeup event missed");

   a_suspend_prep: assert property (
      bus_evt.global_suspend && !bus_evt.resume |=> susp_r[SB_SUSP] && hub_suspend_prep)
      else $error("global suspend not flagged");

   a_resume_prop: assert property (
      bus_evt.resume |=> susp_r[SB_RESUME] && resume_propagate && !hub_suspend_prep)
      else $error("resume not flagged or propagated");

   a_busrst_set: assert property (
      bus_evt.bus_reset && susp_en_r[SB_BUSRST] |=> susp_r[SB_BUSRST])
      else $error("bus reset event missed");

   a_in_no_out: assert property (
      ep_evt[1].rx_out_set && !ep_evt[1].tx_cmpl_set && ep_dir_r[1] && !status_r[BIT_FE1]
      |=> !status_r[BIT_FE1])
      else $error("out packet set an in endpoint");

   a_ctrl_setup: assert property (
      ep_evt[0].rx_setup_set |=> status_r[BIT_FE0])
      else $error("setup missed on control endpoint");

   a_irq_quiet: assert property (
      ((status_r & enable_r & ~mask_r) == 8'h00)
      && ((susp_r & susp_en_r & ~susp_mask_r) == 4'h0) |=> !usb_irq)
      else $error("interrupt with nothing unmasked");

   a_ack_set_wins: assert property (
      wr && idx == IDX_ACK && bus_evt.sof_valid |=> status_r[BIT_SOF])
      else $error("acknowledge beat a new event");

   // main scenarios seen
   c_sof_irq:  cover property (bus_evt.sof_valid ##[1:3] usb_irq);
   c_eof2:     cover property (eof2_hit);
   c_ack_race: cover property (wr && idx == IDX_ACK && |set_vec);
   c_suspend:  cover property (bus_evt.global_suspend ##[1:20] bus_evt.resume);
   c_bus_reset: cover property (bus_evt.bus_reset && susp_en_r[SB_BUSRST]);

endmodule // usb_irq_sources

/* File: testbench/usb_engine_model.sv */
module usb_engine_model
   import usb_irq_pkg::*;
(
   // clock and reset
   input  wire logic      pclk,
   input  wire logic      presetn,
   // events toward the block
   output bus_evt_type    bus_evt,
   output logic [10:0]    sof_frame,
   output ep_csr_evt_type ep_evt [N_EP]
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet lines at time zero
   initial begin
      bus_evt   = '0;
      sof_frame = 11'h000;
      for (int i = 0; i < N_EP; i++) ep_evt[i] = '0;
   end

   // bus event pulses
   // frame lines show the inverse once released, never a stale value
   task automatic bus_pulse(input bus_evt_type e, input logic [10:0] f);
      @(posedge pclk);
      bus_evt   <= e;
      sof_frame <= f;
      @(posedge pclk);
      bus_evt   <= '0;
      sof_frame <= ~f;
   endtask

   task automatic ep_pulse(input int s, input ep_csr_evt_type e);
      @(posedge pclk);
      ep_evt[s] <= e;
      @(posedge pclk);
      ep_evt[s] <= '0;
   endtask
endmodule // usb_engine_model

/* File: testbench/usb_interrupt_sources_test.sv */
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module usb_interrupt_sources_test;
   import usb_irq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FL = 64;
   logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic           hub_suspend_prep, resume_propagate, usb_irq;
   logic [15:0]    paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic [15:0]    seed = 16'hac71;
   bus_evt_type    bus_evt;
   logic [10:0]    sof_frame;
   ep_csr_evt_type ep_evt [N_EP];
   int             n_mismatch = 0;
   int             total_checks = 0;
   int             st, en, mk, ss, sen, smk, dir;
   logic [12:0]    idx_list [7] = '{IDX_STATUS, IDX_MASK, IDX_ACK, IDX_ENABLE,
                                    IDX_SUSP_STAT, IDX_SUSP_EN, IDX_SUSP_MASK};

   usb_irq_sources #(.FRAME_LEN(FL)) usb_irq_sources_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_evt(bus_evt), .sof_frame(sof_frame), .ep_evt(ep_evt),
      .hub_suspend_prep(hub_suspend_prep), .resume_propagate(resume_propagate),
      .usb_irq(usb_irq));
   usb_engine_model usb_engine_model_inst (
      .pclk(pclk), .presetn(presetn), .bus_evt(bus_evt), .sof_frame(sof_frame),
      .ep_evt(ep_evt));

   // 40 mhz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // endpoint slot to status bit
   function automatic int ebit(input int s);
      return (s == 3) ? 4 : ((s == 4) ? 3 : s);
   endfunction

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [12:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {1'b0, idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // suspend status write: low two bits kept by one, high two cleared by one
   task automatic susp_wr(input int w);
      apb(1'b1, IDX_SUSP_STAT, 32'(w));
      ss = (ss & w & 3) | (ss & ~w & 12);
   endtask

   // compare interrupt line and both status registers with the model
   task automatic check_all();
      logic exp_irq;
      repeat (2) @(posedge pclk);
      exp_irq = ((st & en & ~mk) != 0) || ((ss & sen & ~smk) != 0);
      #1;
      `CHK(usb_irq, exp_irq)
      apb(1'b0, IDX_STATUS, 32'h0);
      `CHK(rd, 32'(st))
      apb(1'b0, IDX_SUSP_STAT, 32'h0);
      `CHK(rd, 32'(ss))
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      conclude();
   end

   // main sequence
   initial begin
      ep_csr_evt_type e;
      logic           ctl, inn;
      logic [10:0]    f;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {st, en, mk, ss, sen, smk} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (idx_list[i]) begin
         apb(1'b0, idx_list[i], 32'h0);
         `CHK(rd, 32'h0)
      end
      // unmapped index refused
      apb(1'b1, 13'h1ff4, 32'hff);
      `CHK(err, 1'b1)
      apb(1'b1, IDX_ENABLE, 32'hff);
      en = 8'hdf;
      apb(1'b0, IDX_ENABLE, 32'h0);
      `CHK(rd, 32'hdf)
      // endpoints with random strobes, all OUT then 1..3 IN
      for (int d = 0; d < 2; d++) begin
         dir = d ? 32'he : 32'h0;
         apb(1'b1, IDX_EP_DIR, 32'(dir));
         for (int s = 0; s < N_EP; s++) begin
            for (int k = 0; k < 4; k++) begin
               seed = lfsr(seed);
               e    = seed[3:0];
               ctl  = (s == 0) || (s == EP_HUB0);
               inn  = !ctl && dir[s];
               usb_engine_model_inst.ep_pulse(s, e);
               if ((e.rx_out_set && (ctl || !inn)) || e.tx_cmpl_set || (e.rx_setup_set && ctl))
                  st |= 1 << ebit(s);
               check_all();
               apb(1'b1, IDX_ACK, 32'hff);
               st = 0;
            end
         end
      end
      // masking and acknowledge
      usb_engine_model_inst.ep_pulse(0, 4'h2);
      st = 1;
      apb(1'b1, IDX_MASK, 32'h01);
      mk = 1;
      check_all();
      apb(1'b1, IDX_ACK, 32'h01);
      st = 0;
      check_all();
      // suspend, resume, wakeup
      apb(1'b1, IDX_SUSP_EN, 32'h1);
      sen = 1;
      usb_engine_model_inst.bus_pulse(5'b00100, 11'h0);
      ss |= 1;
      check_all();
      `CHK(hub_suspend_prep, 1'b1)
      susp_wr(1);
      check_all();
      susp_wr(0);
      check_all();
      usb_engine_model_inst.bus_pulse(5'b00010, 11'h0);
      #1;
      `CHK(resume_propagate, 1'b1)
      @(posedge pclk);
      #1;
      `CHK({resume_propagate, hub_suspend_prep}, 2'b00)
      ss |= 2;
      usb_engine_model_inst.bus_pulse(5'b01000, 11'h0);
      ss |= 4;
      check_all();
      susp_wr(6);
      check_all();
      // bus reset only with separation on
      usb_engine_model_inst.bus_pulse(5'b00001, 11'h0);
      check_all();
      apb(1'b1, IDX_SUSP_EN, 32'h9);
      sen = 9;
      usb_engine_model_inst.bus_pulse(5'b00001, 11'h0);
      ss |= 8;
      check_all();
      apb(1'b1, IDX_SUSP_MASK, 32'h9);
      smk = 9;
      check_all();
      // frame start, frame number and end-of-frame point
      apb(1'b1, IDX_MASK, 32'h0);
      mk   = 0;
      seed = lfsr(seed);
      f    = seed[10:0];
      usb_engine_model_inst.bus_pulse(5'b10000, f);
      repeat (FL - 14) @(posedge pclk);
      apb(1'b0, IDX_STATUS, 32'h0);
      `CHK(rd, 32'h80)
      repeat (4) @(posedge pclk);
      st = 8'hc0;
      check_all();
      apb(1'b0, IDX_FRAME_LO, 32'h0);
      `CHK(rd, 32'(f[7:0]))
      apb(1'b0, IDX_FRAME_HI, 32'h0);
      `CHK(rd, 32'(f[10:8]))
      conclude();
   end
endmodule // usb_interrupt_sources_test
